// ### rtl/cpc_byte_mem.sv
// 256-byte packet buffer with registered read data
`timescale 1ns/10ps
`default_nettype none
module cpc_byte_mem (
	input wire logic clk,
	input wire logic we,
	input wire logic [7:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] raddr,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:255];
	logic [7:0] rdata_reg;

	// Write port
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Registered read port
	always_ff @(posedge clk) begin
		rdata_reg <= mem[raddr];
	end

	assign rdata = rdata_reg;
endmodule
`default_nettype wire

// ### rtl/cpc_host_ctrl.sv
// Host controller that frames command packets and checks the replies
//
// Notes on behaviour
// [R1] Normal command byte: destination bit 7, command 0-14 in 6:3, words in 2:0.
// [R2] Normal packet: one command word plus 0-7 data words at bytes 2-15.
// [R3] Command field all ones marks extended; bits 2:0 are a sub-field.
// [R4] Extended packet: three command words plus 0-125 data words.
// [R5] Extended: byte 2 words, byte 3 command, bytes 4-5 payload sum, data 6-255.
// [R6] Normal header sum in byte 0 covers bytes 1 onward.
// [R7] Extended header sum covers bytes 1-5, payload sum bytes included.
// [R8] Payload sum adds every byte from 6 onward into 16 bits.
// [R9] Sums are ones-complement: carry out is added back as one.
// [R10] Header sum: 16-bit accumulate, fold high plus low twice, keep low byte.
// [R11] Device ignores the destination bit.
// [R12] Multi-byte values go least significant byte first.
// [R13] Device updates parameters whose write-select bit is set, else only reports.
// [R14] Analog channel mask is 16 bits, bit n selects input n.
// [R15] Digital mask bit set updates direction and state, clear only reads.
// [R16] Bad checksum gives two-byte reply 0xB8 0xB8, nothing else done.
// [R17] Data words are two bytes; length is header plus twice word count.
`timescale 1ns/10ps
`default_nettype none
module cpc_host_ctrl
	import cpc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire cpc_cmd_t cmd,
	input wire logic cmd_valid,
	output logic cmd_ready,
	output logic cmd_reject,
	input wire logic buf_wr_en,
	input wire logic [7:0] buf_wr_addr,
	input wire logic [7:0] buf_wr_data,
	input wire logic [7:0] buf_rd_addr,
	output logic [7:0] buf_rd_data,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [7:0] tx_data,
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic [7:0] rx_data,
	input wire logic rx_last,
	output logic rsp_done,
	output cpc_status_t rsp_status
);
	typedef enum logic [7:0] {
		S_IDLE = 8'h01,
		S_SUM = 8'h02,
		S_HDR = 8'h04,
		S_FETCH = 8'h08,
		S_LOAD = 8'h10,
		S_PUT = 8'h20,
		S_RECV = 8'h40,
		S_CHECK = 8'h80
	} cpc_state_t;

	cpc_state_t state_reg, state_next;
	cpc_cmd_t cmd_reg;
	logic [8:0] len_reg;
	logic [8:0] hdr_len_reg;
	logic [8:0] sum_ptr_reg;
	logic pend_reg;
	logic [8:0] send_ptr_reg;
	logic [7:0] tx_data_reg;
	logic [7:0] byte1_reg;
	logic [7:0] sum8_reg;
	logic [15:0] p16_reg;
	logic [8:0] rx_cnt_reg;
	logic [7:0] rx_b0_reg, rx_b1_reg, rx_b4_reg, rx_b5_reg;
	logic rsp_done_reg;
	cpc_status_t status_reg;
	logic cmd_legal, cmd_take, issue_rd, rx_take;
	logic [7:0] cmd_byte;
	logic [8:0] len_calc;
	logic [15:0] tx_acc, rx_all_acc, rx_pay_acc, rx_hdr_acc;
	logic [15:0] ext_hdr16;
	logic [7:0] mem_waddr, mem_wdata, mem_raddr, mem_rdata;
	logic mem_we;

	// Command acceptance and legality
	always_comb begin
		if (cmd.extended) begin
			cmd_legal = (cmd.words <= CPC_EXT_MAX_WORDS); // [R4]
		end else begin
			cmd_legal = (cmd.cmd_num != CPC_EXT_CODE); // [R1]
		end
	end
	assign cmd_ready = (state_reg == S_IDLE);
	assign cmd_take = cmd_valid && cmd_ready && cmd_legal;
	assign cmd_reject = cmd_valid && cmd_ready && !cmd_legal;

	// Packet length from word count, two bytes per word
	always_comb begin
		if (cmd.extended) begin
			len_calc = CPC_EXT_HDR_LEN + {cmd.words, 1'b0}; // [R17] [R5]
		end else begin
			len_calc = CPC_NORM_HDR_LEN + {5'h00, cmd.words[CPC_WRD_MSB:0], 1'b0}; // [R17] [R2]
		end
	end

	// Command byte assembly
	always_comb begin
		if (cmd_reg.extended) begin
			cmd_byte = {cmd_reg.dest, CPC_EXT_CODE, cmd_reg.sub}; // [R3]
		end else begin
			cmd_byte = {cmd_reg.dest, cmd_reg.cmd_num, cmd_reg.words[CPC_WRD_MSB:0]}; // [R1]
		end
	end

	// Extended header span: bytes 1 to 5, payload sum low byte first
	assign ext_hdr16 = {8'h00, byte1_reg} + {8'h00, cmd_reg.words} + {8'h00, cmd_reg.ext_cmd}
		+ {8'h00, p16_reg[7:0]} + {8'h00, p16_reg[15:8]}; // [R7] [R12]

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= S_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Sequencer
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			S_IDLE: begin
				if (cmd_take) begin
					state_next = S_SUM;
				end
			end
			S_SUM: begin
				if (!issue_rd && !pend_reg) begin
					state_next = S_HDR;
				end
			end
			S_HDR: state_next = S_FETCH;
			S_FETCH: state_next = S_LOAD;
			S_LOAD: state_next = S_PUT;
			S_PUT: begin
				if (tx_ready) begin
					state_next = (send_ptr_reg == len_reg - 9'h001) ? S_RECV : S_FETCH;
				end
			end
			S_RECV: begin
				if (rx_valid && rx_last) begin
					state_next = S_CHECK;
				end
			end
			S_CHECK: state_next = S_IDLE;
			default: state_next = S_IDLE;
		endcase
	end

	// Command capture
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_reg <= '0;
			len_reg <= 9'h000;
			hdr_len_reg <= 9'h000;
		end else if (cmd_take) begin
			cmd_reg <= cmd;
			len_reg <= len_calc;
			hdr_len_reg <= cmd.extended ? CPC_EXT_HDR_LEN : CPC_NORM_HDR_LEN;
		end
	end

	// Data pass over the buffer to form the running sum
	assign issue_rd = (state_reg == S_SUM) && (sum_ptr_reg < len_reg);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sum_ptr_reg <= 9'h000;
			pend_reg <= 1'b0;
		end else begin
			pend_reg <= issue_rd;
			if (cmd_take) begin
				sum_ptr_reg <= cmd.extended ? CPC_EXT_HDR_LEN : CPC_NORM_HDR_LEN; // [R8]
			end else if (issue_rd) begin
				sum_ptr_reg <= sum_ptr_reg + 9'h001;
			end
		end
	end

	// Header bytes and sums
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			byte1_reg <= 8'h00;
			p16_reg <= 16'h0000;
			sum8_reg <= 8'h00;
		end else if (state_reg == S_SUM) begin
			byte1_reg <= cmd_byte;
			p16_reg <= tx_acc; // [R8]
		end else if (state_reg == S_HDR) begin
			if (cmd_reg.extended) begin
				sum8_reg <= cpc_fold8(ext_hdr16); // [R7] [R10]
			end else begin
				sum8_reg <= cpc_fold8(cpc_ones_add(tx_acc, byte1_reg)); // [R6] [R10]
			end
		end
	end

	// Transmit byte selection and pointer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			send_ptr_reg <= 9'h000;
			tx_data_reg <= 8'h00;
		end else begin
			if (state_reg == S_HDR) begin
				send_ptr_reg <= 9'h000;
			end else if (state_reg == S_PUT && tx_ready) begin
				send_ptr_reg <= send_ptr_reg + 9'h001;
			end
			if (state_reg == S_LOAD) begin
				if (send_ptr_reg >= hdr_len_reg) begin
					tx_data_reg <= mem_rdata;
				end else begin
					unique case (send_ptr_reg[2:0])
						CPC_POS_SUM8[2:0]: tx_data_reg <= sum8_reg;
						CPC_POS_CMD[2:0]: tx_data_reg <= byte1_reg;
						CPC_POS_WORDS[2:0]: tx_data_reg <= cmd_reg.words; // [R5]
						CPC_POS_EXTCMD[2:0]: tx_data_reg <= cmd_reg.ext_cmd; // [R5]
						CPC_POS_P16_LO[2:0]: tx_data_reg <= p16_reg[7:0]; // [R12]
						CPC_POS_P16_HI[2:0]: tx_data_reg <= p16_reg[15:8]; // [R12]
						default: tx_data_reg <= 8'h00;
					endcase
				end
			end
		end
	end
	assign tx_valid = (state_reg == S_PUT);
	assign tx_data = tx_data_reg;

	// Reply capture
	assign rx_ready = (state_reg == S_RECV);
	assign rx_take = rx_ready && rx_valid;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_cnt_reg <= 9'h000;
			rx_b0_reg <= 8'h00;
			rx_b1_reg <= 8'h00;
			rx_b4_reg <= 8'h00;
			rx_b5_reg <= 8'h00;
		end else if (state_reg == S_HDR) begin
			rx_cnt_reg <= 9'h000;
		end else if (rx_take) begin
			rx_cnt_reg <= rx_cnt_reg + 9'h001;
			unique case (rx_cnt_reg)
				{1'b0, CPC_POS_SUM8}: rx_b0_reg <= rx_data;
				{1'b0, CPC_POS_CMD}: rx_b1_reg <= rx_data;
				{1'b0, CPC_POS_P16_LO}: rx_b4_reg <= rx_data;
				{1'b0, CPC_POS_P16_HI}: rx_b5_reg <= rx_data;
				default: ;
			endcase
		end
	end

	// Reply check
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status_reg <= '0;
			rsp_done_reg <= 1'b0;
		end else begin
			rsp_done_reg <= (state_reg == S_CHECK);
			if (state_reg == S_CHECK) begin
				status_reg.length <= rx_cnt_reg;
				status_reg.extended <= (rx_b1_reg[CPC_CMD_MSB:CPC_CMD_LSB] == CPC_EXT_CODE); // [R3]
				if (rx_cnt_reg == CPC_FAIL_LEN && rx_b0_reg == CPC_FAIL_BYTE
					&& rx_b1_reg == CPC_FAIL_BYTE) begin
					status_reg.fail_reply <= 1'b1; // [R16]
					status_reg.hdr_bad <= 1'b0;
					status_reg.pay_bad <= 1'b0;
				end else if (rx_b1_reg[CPC_CMD_MSB:CPC_CMD_LSB] == CPC_EXT_CODE) begin
					status_reg.fail_reply <= 1'b0;
					status_reg.hdr_bad <= (rx_b0_reg != cpc_fold8(rx_hdr_acc)); // [R7] [R10]
					status_reg.pay_bad <= ({rx_b5_reg, rx_b4_reg} != rx_pay_acc); // [R8] [R12]
				end else begin
					status_reg.fail_reply <= 1'b0;
					status_reg.hdr_bad <= (rx_b0_reg != cpc_fold8(rx_all_acc)); // [R6] [R10]
					status_reg.pay_bad <= 1'b0;
				end
			end
		end
	end
	assign rsp_done = rsp_done_reg;
	assign rsp_status = status_reg;

	// Buffer ports: user in idle, reply bytes during receive
	always_comb begin
		mem_we = 1'b0;
		mem_waddr = buf_wr_addr;
		mem_wdata = buf_wr_data;
		if (state_reg == S_IDLE) begin
			mem_we = buf_wr_en;
		end else if (rx_take) begin
			mem_we = 1'b1;
			mem_waddr = rx_cnt_reg[7:0];
			mem_wdata = rx_data;
		end
	end
	always_comb begin
		if (state_reg == S_SUM) begin
			mem_raddr = sum_ptr_reg[7:0];
		end else if (state_reg == S_FETCH) begin
			mem_raddr = send_ptr_reg[7:0];
		end else begin
			mem_raddr = buf_rd_addr;
		end
	end
	assign buf_rd_data = mem_rdata;

	cpc_byte_mem u_mem (
		.clk(clk),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(mem_raddr),
		.rdata(mem_rdata)
	);

	// Transmit data sum
	cpc_ones_acc u_tx_acc (
		.clk(clk),
		.rst_n(rst_n),
		.clear(cmd_take),
		.add(pend_reg),
		.din(mem_rdata),
		.sum(tx_acc)
	);

	// Reply sums: all from byte 1, payload from byte 6, header bytes 1 to 5
	cpc_ones_acc u_rx_all (
		.clk(clk),
		.rst_n(rst_n),
		.clear(state_reg == S_HDR),
		.add(rx_take && rx_cnt_reg != 9'h000),
		.din(rx_data),
		.sum(rx_all_acc)
	);
	cpc_ones_acc u_rx_pay (
		.clk(clk),
		.rst_n(rst_n),
		.clear(state_reg == S_HDR),
		.add(rx_take && rx_cnt_reg >= CPC_EXT_HDR_LEN),
		.din(rx_data),
		.sum(rx_pay_acc)
	);
	cpc_ones_acc u_rx_hdr (
		.clk(clk),
		.rst_n(rst_n),
		.clear(state_reg == S_HDR),
		.add(rx_take && rx_cnt_reg != 9'h000 && rx_cnt_reg < CPC_EXT_HDR_LEN),
		.din(rx_data),
		.sum(rx_hdr_acc)
	);
endmodule
`default_nettype wire

// ### rtl/cpc_ones_acc.sv
// Byte-serial ones-complement accumulator
`timescale 1ns/10ps
`default_nettype none
module cpc_ones_acc
	import cpc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic add,
	input wire logic [7:0] din,
	output logic [15:0] sum
);
	logic [15:0] sum_reg;

	// Clear wins over add; carry added back in
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sum_reg <= 16'h0000;
		end else if (clear) begin
			sum_reg <= 16'h0000;
		end else if (add) begin
			sum_reg <= cpc_ones_add(sum_reg, din); // [R9]
		end
	end

	assign sum = sum_reg;
endmodule
`default_nettype wire

// ### shared/cpc_pkg.sv
// Constants, carriers and checksum helpers for the command packet controller
`default_nettype none
package cpc_pkg;

	// Byte positions inside a packet
	localparam logic [7:0] CPC_POS_SUM8 = 8'h00;
	localparam logic [7:0] CPC_POS_CMD = 8'h01;
	localparam logic [7:0] CPC_POS_WORDS = 8'h02;
	localparam logic [7:0] CPC_POS_EXTCMD = 8'h03;
	localparam logic [7:0] CPC_POS_P16_LO = 8'h04;
	localparam logic [7:0] CPC_POS_P16_HI = 8'h05;

	// Header lengths, which are also the first data positions
	localparam logic [8:0] CPC_NORM_HDR_LEN = 9'h002;
	localparam logic [8:0] CPC_EXT_HDR_LEN = 9'h006;

	// Command byte fields
	localparam int CPC_DEST_BIT = 7;
	localparam int CPC_CMD_MSB = 6;
	localparam int CPC_CMD_LSB = 3;
	localparam int CPC_WRD_MSB = 2;
	localparam logic [3:0] CPC_EXT_CODE = 4'hF;

	// Limits on the word count
	localparam logic [7:0] CPC_EXT_MAX_WORDS = 8'h7D;

	// Checksum failure reply
	localparam logic [7:0] CPC_FAIL_BYTE = 8'hB8;
	localparam logic [8:0] CPC_FAIL_LEN = 9'h002;

	// Command handed in by the user
	typedef struct packed {
		logic extended;
		logic dest;
		logic [3:0] cmd_num;
		logic [2:0] sub;
		logic [7:0] ext_cmd;
		logic [7:0] words;
	} cpc_cmd_t;

	// Result of checking one reply
	typedef struct packed {
		logic fail_reply;
		logic hdr_bad;
		logic pay_bad;
		logic extended;
		logic [8:0] length;
	} cpc_status_t;

	// Ones-complement add of one byte, carry folded back in
	function automatic logic [15:0] cpc_ones_add(input logic [15:0] acc, input logic [7:0] b);
		logic [16:0] s;
		s = {1'b0, acc} + {9'h000, b};
		return s[15:0] + {15'h0000, s[16]};
	endfunction

	// Fold a 16-bit accumulator twice into an 8-bit sum
	function automatic logic [7:0] cpc_fold8(input logic [15:0] acc);
		logic [15:0] t;
		logic [15:0] u;
		t = {8'h00, acc[15:8]} + {8'h00, acc[7:0]};
		u = {8'h00, t[15:8]} + {8'h00, t[7:0]};
		return u[7:0];
	endfunction

endpackage
`default_nettype wire

// ### tb/command_packet_checker_bench.sv
// Self-checking bench for the command packet host controller
`timescale 1ns/10ps
`default_nettype none
module command_packet_checker_bench
	import cpc_pkg::*;
;
	typedef struct packed {
		logic ext;
		logic dest;
		logic [3:0] num;
		logic [2:0] sub;
		logic [7:0] xc;
		logic [7:0] words;
		logic [1:0] mode;
		logic f;
		logic h;
		logic p;
	} cpc_row_t;
	cpc_row_t rows [8] = '{
		'{1'b0, 1'b0, 4'h3, 3'h0, 8'h00, 8'h00, 2'h0, 1'b0, 1'b0, 1'b0},
		'{1'b0, 1'b1, 4'hE, 3'h0, 8'h00, 8'h07, 2'h0, 1'b0, 1'b0, 1'b0},
		'{1'b0, 1'b0, 4'h5, 3'h0, 8'h00, 8'h02, 2'h3, 1'b0, 1'b1, 1'b0},
		'{1'b0, 1'b0, 4'h0, 3'h0, 8'h00, 8'h01, 2'h1, 1'b1, 1'b0, 1'b0},
		'{1'b1, 1'b1, 4'h0, 3'h5, 8'h0B, 8'h00, 2'h0, 1'b0, 1'b0, 1'b0},
		'{1'b1, 1'b0, 4'h0, 3'h0, 8'h02, 8'h03, 2'h3, 1'b0, 1'b0, 1'b1},
		'{1'b1, 1'b0, 4'h0, 3'h7, 8'h2A, 8'h01, 2'h2, 1'b0, 1'b1, 1'b0},
		'{1'b1, 1'b0, 4'h0, 3'h0, 8'h10, 8'h7D, 2'h0, 1'b0, 1'b0, 1'b0}
	};
	logic clk;
	logic rst_n = 1'b0;
	cpc_cmd_t cmd = '0;
	logic cmd_valid = 1'b0;
	logic buf_wr_en = 1'b0;
	logic [7:0] buf_wr_addr = 8'h00;
	logic [7:0] buf_wr_data = 8'h00;
	logic [7:0] buf_rd_addr = 8'h00;
	logic [1:0] mode = 2'h0;
	logic slow = 1'b0;
	logic cmd_ready, cmd_reject, tx_valid, tx_ready, rx_valid, rx_ready, rx_last, rsp_done;
	logic sums_ok;
	logic [7:0] buf_rd_data, tx_data, rx_data;
	logic [8:0] got_len;
	cpc_status_t rsp_status;
	int mismatches = 0;
	int n_checks = 0;
	// Clock at 200 MHz
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	cpc_host_ctrl DUT (.clk, .rst_n, .cmd, .cmd_valid, .cmd_ready, .cmd_reject, .buf_wr_en,
		.buf_wr_addr, .buf_wr_data, .buf_rd_addr, .buf_rd_data, .tx_valid, .tx_ready,
		.tx_data, .rx_valid, .rx_ready, .rx_data, .rx_last, .rsp_done, .rsp_status);
	cpc_dev_model dev (.clk, .rst_n, .mode, .slow, .tx_valid, .tx_ready, .tx_data,
		.rx_valid, .rx_ready, .rx_data, .rx_last, .sums_ok, .got_len);
	task automatic wrap_up();
		if (mismatches == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// One command through to its checked reply
	task automatic run_row(input cpc_row_t r, input logic s);
		cpc_status_t e;
		logic [8:0] ln;
		logic [7:0] lp;
		logic [7:0] b1;
		int k;
		ln = r.ext ? 9'h006 + {r.words, 1'b0} : 9'h002 + {5'h00, r.words[2:0], 1'b0};
		lp = ln[7:0] - 8'h01;
		b1 = r.ext ? {r.dest, 4'hF, r.sub} : {r.dest, r.num, r.words[2:0]};
		e = {r.f, r.h, r.p, r.ext, r.f ? 9'h002 : ln};
		for (k = 0; k < 256; k++) begin
			buf_wr_en = 1'b1;
			buf_wr_addr = k[7:0];
			buf_wr_data = k[7:0] ^ 8'hA5;
			@(negedge clk);
		end
		buf_wr_en = 1'b0;
		mode = r.mode;
		slow = s;
		cmd = {r.ext, r.dest, r.num, r.sub, r.xc, r.words};
		cmd_valid = 1'b1;
		#1 chk(16'(cmd_reject), 16'h0000);
		@(negedge clk);
		cmd_valid = 1'b0;
		for (k = 0; k < 4000 && rsp_done !== 1'b1; k++) @(negedge clk);
		if (rsp_done !== 1'b1) begin
			mismatches++;
			$display("CHECK FAILED %0t: no reply", $time);
		end
		chk(16'(rsp_status), 16'(e));
		chk(16'(got_len), 16'(ln));
		chk(16'(sums_ok), 16'h0001);
		chk(16'(dev.pkt[1]), 16'(b1));
		if (r.ext) chk(16'({dev.pkt[2], dev.pkt[3]}), 16'({r.words, r.xc}));
		if (r.words != 8'h00) chk(16'(dev.pkt[lp]), 16'(lp ^ 8'hA5));
	endtask
	// Main sequence
	initial begin
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		for (int i = 0; i < 8; i++) run_row(rows[i], i[0]);
		// Masked parameters after the clean extended rows
		chk(dev.io_state, 16'hFDFD);
		chk(dev.chan_acq, 16'hA2A3);
		// Illegal commands are refused
		cmd = {1'b0, 1'b0, 4'hF, 3'h0, 8'h00, 8'h00};
		cmd_valid = 1'b1;
		#1 chk(16'(cmd_reject), 16'h0001);
		@(negedge clk);
		chk(16'(cmd_ready), 16'h0001);
		cmd = {1'b1, 1'b0, 4'h0, 3'h0, 8'h00, 8'h7E};
		#1 chk(16'(cmd_reject), 16'h0001);
		@(negedge clk);
		cmd_valid = 1'b0;
		chk(16'(cmd_ready), 16'h0001);
		// Failure reply lands in the buffer
		run_row(rows[3], 1'b0);
		buf_rd_addr = 8'h01;
		@(negedge clk);
		chk(16'(buf_rd_data), 16'h00B8);
		// Reset in mid transfer, then a clean packet
		cmd = {1'b0, 1'b0, 4'h2, 3'h0, 8'h00, 8'h07};
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		repeat (30) @(negedge clk);
		rst_n = 1'b0;
		#1 chk(16'({cmd_ready, tx_valid, rx_ready, rsp_done}), 16'h0008);
		chk(16'(rsp_status), 16'h0000);
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		run_row(rows[0], 1'b1);
		wrap_up();
	end
endmodule
`default_nettype wire

// ### tb/cpc_dev_model.sv
// Behavioural device: takes command packets, checks sums, replies
`timescale 1ns/10ps
`default_nettype none
module cpc_dev_model
	import cpc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [1:0] mode,
	input wire logic slow,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [7:0] rx_data,
	output logic rx_last,
	output logic sums_ok,
	output logic [8:0] got_len
);
	logic [7:0] pkt [256];
	logic [8:0] cnt;
	logic [8:0] ri;
	logic [8:0] want;
	logic ext;
	logic busy;
	logic tick;
	logic [15:0] io_state;
	logic [15:0] chan_acq;
	// Length from the command byte, or from byte 2 when extended; destination bit not looked at
	assign ext = pkt[1][6:3] == 4'hF;
	assign want = ext ? 9'h006 + {pkt[2], 1'b0}
		: 9'h002 + {5'h00, pkt[1][2:0], 1'b0};
	assign tx_ready = !busy && (!slow || tick);
	// Ones-complement sums, carry folded back per byte
	function automatic logic good();
		int a;
		int p;
		a = 0;
		p = 0;
		for (int k = 1; k < int'(want); k++) begin
			if (ext && k > 5)
				p = p + pkt[k];
			else
				a = a + pkt[k];
			if (a > 65535) a = a - 65535;
			if (p > 65535) p = p - 65535;
		end
		a = (a >> 8) + (a & 255);
		a = (a >> 8) + (a & 255);
		return pkt[0] == a[7:0] && (!ext || p[15:0] == {pkt[5], pkt[4]});
	endfunction
	// Reply: failure pair, or echo with a commanded corruption
	function automatic logic [7:0] rbyte(input logic [8:0] i);
		if (mode == 2'h1 || !good()) return 8'hB8;
		return pkt[i[7:0]] ^ {7'h00, (mode == 2'h2 && i == 9'h000)
			|| (mode == 2'h3 && i == want - 9'h001)};
	endfunction
	function automatic logic [8:0] nrep();
		return (mode == 2'h1 || !good()) ? 9'h002 : want;
	endfunction
	// Receive, judge, then send the reply
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 9'h000;
			ri <= 9'h000;
			busy <= 1'b0;
			tick <= 1'b0;
			rx_valid <= 1'b0;
			rx_data <= 8'h00;
			rx_last <= 1'b0;
			sums_ok <= 1'b0;
			got_len <= 9'h000;
			io_state <= 16'hFFFF;
			chan_acq <= 16'h0000;
		end else begin
			tick <= ~tick;
			if (tx_valid && tx_ready) begin
				pkt[cnt[7:0]] <= tx_data;
				cnt <= cnt + 9'h001;
			end
			if (!busy && cnt != 9'h000 && cnt == want) begin
				busy <= 1'b1;
				got_len <= cnt;
				sums_ok <= good();
				ri <= 9'h000;
				rx_valid <= 1'b1;
				rx_data <= rbyte(9'h000);
				rx_last <= 1'b0;
				// Masked update only on a clean extended command
				if (ext && mode != 2'h1 && good() && pkt[2] > 8'h01) begin
					io_state <= (io_state & ~{pkt[7], pkt[6]})
						| ({pkt[9], pkt[8]} & {pkt[7], pkt[6]});
					chan_acq <= {pkt[7], pkt[6]};
				end
			end else if (rx_valid && rx_ready) begin
				ri <= ri + 9'h001;
				rx_data <= rbyte(ri + 9'h001);
				rx_last <= ri + 9'h002 == nrep();
				if (rx_last) begin
					rx_valid <= 1'b0;
					rx_last <= 1'b0;
					busy <= 1'b0;
					cnt <= 9'h000;
					rx_data <= ~rx_data;
				end
			end else if (!rx_valid) begin
				rx_data <= ~rx_data; // Released line keeps moving
			end
		end
	end
endmodule
`default_nettype wire

// ### tb/cpc_host_ctrl_sva.sv
// Assertion checker for the command packet host controller
`timescale 1ns/10ps
`default_nettype none
module cpc_host_ctrl_sva
	import cpc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire cpc_cmd_t cmd,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic cmd_reject,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic [7:0] tx_data,
	input wire logic rx_valid,
	input wire logic rx_ready,
	input wire logic rx_last,
	input wire logic rsp_done,
	input wire cpc_status_t rsp_status
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Request offered while idle
	sequence s_offer;
		cmd_valid && cmd_ready;
	endsequence
	// Last reply byte taken
	sequence s_last_rx;
		rx_valid && rx_ready && rx_last;
	endsequence
	a_reject_when_idle: assert property (cmd_reject |-> cmd_valid && cmd_ready)
		else $error("reject without idle request");
	a_reject_bad_num: assert property (s_offer ##0 (!cmd.extended && cmd.cmd_num == 4'hF) |-> cmd_reject)
		else $error("command 15 not refused");
	a_reject_ext_words: assert property (s_offer ##0 (cmd.extended && cmd.words > 8'h7D) |-> cmd_reject)
		else $error("word count above 125 not refused");
	a_take_goes_busy: assert property (s_offer ##0 !cmd_reject |=> !cmd_ready)
		else $error("taken command left block idle");
	a_tx_byte_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("transmit byte dropped or changed");
	a_done_after_last: assert property (s_last_rx |-> ##[2:3] rsp_done)
		else $error("no check result after last byte");
	a_done_ready: assert property (rsp_done |-> cmd_ready && !$past(rsp_done))
		else $error("done not a single idle pulse");
	a_fail_flags: assert property (rsp_done && rsp_status.fail_reply |->
		!rsp_status.hdr_bad && !rsp_status.pay_bad && rsp_status.length == 9'h002)
		else $error("failure reply status wrong");
endmodule
bind cpc_host_ctrl cpc_host_ctrl_sva u_sva (.clk, .rst_n, .cmd, .cmd_valid, .cmd_ready,
	.cmd_reject, .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_ready, .rx_last,
	.rsp_done, .rsp_status);
`default_nettype wire
